// ### core/slm_consts.svh
// Offsets, field positions, codes and timing constants of the status/register block
`ifndef SLM_CONSTS_SVH
`define SLM_CONSTS_SVH
// ---------------------------------------------------------------
// Register word addresses
// ---------------------------------------------------------------
`define SLM_ADDR_CMD 16'h07D6
`define SLM_ADDR_SUM 16'h1F3C
`define SLM_ADDR_DET 16'h1F3D
`define SLM_ADDR_IN 16'h1F40
`define SLM_BIT_BASE 16'h0000
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SLM_SUM_ERR 0
`define SLM_DET_US_UNDER 2
`define SLM_DET_US_SURGE 3
`define SLM_DET_US_OVL 4
`define SLM_DET_OVERTEMP 10
`define SLM_CMD_CLR 7
// ---------------------------------------------------------------
// Function and exception codes
// ---------------------------------------------------------------
`define SLM_FC_RD_COILS 8'h01
`define SLM_FC_RD_DISC 8'h02
`define SLM_FC_RD_HOLD 8'h03
`define SLM_FC_RD_INREG 8'h04
`define SLM_FC_WR_COIL 8'h05
`define SLM_FC_WR_REG 8'h06
`define SLM_FC_WR_COILS 8'h0F
`define SLM_FC_WR_REGS 8'h10
`define SLM_FC_RW_REGS 8'h17
`define SLM_EXC_NONE 8'h00
`define SLM_EXC_FUNC 8'h01
`define SLM_EXC_ADDR 8'h02
`define SLM_EXC_VALUE 8'h03
`define SLM_EXC_FAIL 8'h04
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SLM_CLK_HZ 50000000
`define SLM_BLINK_HALF_MS 250
`define SLM_BLINK_HALF_CYC ((`SLM_CLK_HZ / 1000) * `SLM_BLINK_HALF_MS)
`endif

// ### core/slm_pkg.sv
// Types of the status/register block
package slm_pkg;
  typedef enum logic [1:0] {SLM_OFF, SLM_GRN, SLM_YEL, SLM_RED} slm_led_e;
  typedef struct packed {
    logic valid;
    logic [7:0] fc;
    logic wr;
    logic [2:0] conn;
    logic [15:0] addr;
    logic [15:0] wdata;
  } slm_req_s;
  typedef struct packed {
    logic valid;
    logic [7:0] exc;
    logic [15:0] data;
  } slm_rsp_s;
  typedef struct packed {
    logic open;
    logic close;
    logic [2:0] id;
  } slm_conn_s;
  typedef struct packed {
    logic [23:0] cnt;
    logic blink;
    logic [7:0] conn_open;
    logic [15:0] fault;
    logic cmd_err;
    slm_rsp_s rsp;
    logic [1:0] link;
    logic [1:0] traffic;
    slm_led_e rdy;
    slm_led_e net;
    slm_led_e us;
    logic ua;
    logic [15:0] in_led;
  } slm_state_s;
endpackage : slm_pkg

// ### core/slm_top.sv
// Indicator drivers and Modbus register access of the 16-input station
//
// Function
// - Green link light per port follows link-up state.
// - Yellow traffic light per port follows frame transfer activity.
// - Ready light green when operational, flashing during update, dark otherwise.
// - Ready light alternates green/yellow on supply fault or overtemperature.
// - Ready light steady red on invalid or reserved switch setting.
// - Network light flashes green when accepting, steady green with a connection.
// - Network light flashes yellow while requesting address, steady yellow if zero.
// - Network light flashes red on duplicate static address.
// - Network light steady red on connection monitor fault or watchdog expiry.
// - Network light dark while not operational.
// - Sensor supply light green present and not low, dark otherwise, red on overload.
// - Actuator supply light green while present, dark otherwise.
// - Each input light lit while its input is set.
// - Up to eight client connections served at once.
// - Each connection accesses registers independently.
// - Reopening an interrupted connection slot is accepted.
// - Class 0 fully, classes 1 and 2 partly.
// - Function codes 1 and 2 read input bits.
// - Function codes 5 and 15 write no bits, answered with exception 02.
// - Function codes 6, 16 and 23 write words; 23 also reads.
// - Input states returned as word 8000 via codes 3,4,23, as bits 0..15 via codes 1,2.
// - Writes to read-only registers discarded, exception 02.
// - Summary bit 0 set while any fault detail bit is set.
`timescale 1ns/10ps
`include "slm_consts.svh"
module slm_top import slm_pkg::*; #(
  parameter int BLINK_HALF = `SLM_BLINK_HALF_CYC
) (
  input wire logic CLK, // System clock
  input wire logic RST, // Async reset, high
  input wire logic [1:0] LINK_UP, // Link up per port
  input wire logic [1:0] PORT_BUSY, // Frames moving per port
  input wire logic DEV_OPERATIONAL, // Device ready
  input wire logic FW_UPDATING, // Firmware update running
  input wire logic US_UNDER, // Sensor supply low
  input wire logic US_SURGE, // Sensor supply high
  input wire logic US_OVERLOAD, // Sensor supply overload
  input wire logic OVERTEMP, // Temperature critical
  input wire logic SWITCH_INVALID, // Address switch invalid
  input wire logic ADDR_REQUESTING, // BootP/DHCP messages going out
  input wire logic IP_ZERO, // Address is 0.0.0.0
  input wire logic IP_CONFLICT, // Duplicate static address
  input wire logic NET_FAULT, // Connection monitor fault
  input wire logic WDOG_EXPIRED, // Process data watchdog expired
  input wire logic US_PRESENT, // Sensor supply present
  input wire logic UA_PRESENT, // Actuator supply present
  input wire logic [15:0] DIGITAL_INPUT, // Inputs 1..16 at bits 0..15
  input wire slm_conn_s CONN, // Connection open/close event
  input wire slm_req_s REQ, // One-word register request
  output slm_rsp_s RSP, // Answer, one cycle after request
  output logic [7:0] CONN_OPEN, // Open connection slots
  output logic CMD_ERR, // Sticky command error, value zero or multi-bit
  output logic [1:0] PORT_LINK_LIGHT, // Green link lights
  output logic [1:0] PORT_TRAFFIC_LIGHT, // Yellow traffic lights
  output slm_led_e RDY_LED, // Ready light colour
  output slm_led_e NET_LED, // Network light colour
  output slm_led_e SENSOR_SUPPLY_LIGHT, // Sensor supply colour
  output logic ACTUATOR_SUPPLY_LIGHT, // Actuator supply green
  output logic [15:0] IN_LED // Input lights, by input number
);
  slm_state_s s;
  slm_state_s next_s;
  logic [15:0] in_word;
  logic [15:0] live;
  logic [15:0] w1;
  logic onehot;
  logic is_rd;
  logic is_wr;
  logic clr;

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  assign in_word = {DIGITAL_INPUT[7:0], DIGITAL_INPUT[15:8]};
  assign w1 = REQ.wdata - 16'h0001;
  assign onehot = (REQ.wdata != 16'h0000) && ((REQ.wdata & w1) == 16'h0000);
  assign is_rd = (REQ.fc == `SLM_FC_RD_HOLD) || (REQ.fc == `SLM_FC_RD_INREG) ||
                 ((REQ.fc == `SLM_FC_RW_REGS) && !REQ.wr);
  assign is_wr = (REQ.fc == `SLM_FC_WR_REG) || (REQ.fc == `SLM_FC_WR_REGS) ||
                 ((REQ.fc == `SLM_FC_RW_REGS) && REQ.wr);
  assign clr = REQ.valid && s.conn_open[REQ.conn] && is_wr &&
               (REQ.addr == `SLM_ADDR_CMD) && onehot && REQ.wdata[`SLM_CMD_CLR];

  always_comb begin
    live = 16'h0000;
    live[`SLM_DET_US_UNDER] = US_UNDER;
    live[`SLM_DET_US_SURGE] = US_SURGE;
    live[`SLM_DET_US_OVL] = US_OVERLOAD;
    live[`SLM_DET_OVERTEMP] = OVERTEMP;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Shared blink base
    if (s.cnt >= 24'(BLINK_HALF - 1)) begin
      next_s.cnt = 24'h0000;
      next_s.blink = !s.blink;
    end else begin
      next_s.cnt = s.cnt + 24'h0001;
    end
    // Connection slots; opening a busy slot replaces it
    if (CONN.close) begin
      next_s.conn_open[CONN.id] = 1'b0;
    end
    if (CONN.open) begin
      next_s.conn_open[CONN.id] = 1'b1;
    end
    // Latched faults, new events win over the clear command
    next_s.fault = (clr ? 16'h0000 : s.fault) | live;
    // Answer
    next_s.rsp.valid = REQ.valid;
    next_s.rsp.exc = `SLM_EXC_NONE;
    next_s.rsp.data = 16'h0000;
    if (REQ.valid) begin
      if (!s.conn_open[REQ.conn]) begin
        next_s.rsp.exc = `SLM_EXC_FAIL;
      end else if ((REQ.fc == `SLM_FC_RD_COILS) || (REQ.fc == `SLM_FC_RD_DISC)) begin
        if ((REQ.addr & 16'hFFF0) == `SLM_BIT_BASE) begin
          next_s.rsp.data = {15'h0000, in_word[REQ.addr[3:0]]};
        end else begin
          next_s.rsp.exc = `SLM_EXC_ADDR;
        end
      end else if ((REQ.fc == `SLM_FC_WR_COIL) || (REQ.fc == `SLM_FC_WR_COILS)) begin
        next_s.rsp.exc = `SLM_EXC_ADDR;
      end else if (is_rd) begin
        unique case (REQ.addr)
          `SLM_ADDR_SUM: next_s.rsp.data = {15'h0000, |s.fault};
          `SLM_ADDR_DET: next_s.rsp.data = s.fault;
          `SLM_ADDR_IN: next_s.rsp.data = in_word;
          default: next_s.rsp.exc = `SLM_EXC_ADDR;
        endcase
      end else if (is_wr) begin
        if (REQ.addr != `SLM_ADDR_CMD) begin
          next_s.rsp.exc = `SLM_EXC_ADDR;
        end else if (!onehot) begin
          next_s.rsp.exc = `SLM_EXC_VALUE;
          next_s.cmd_err = 1'b1;
        end
      end else begin
        next_s.rsp.exc = `SLM_EXC_FUNC;
      end
    end
    // Simple lights
    next_s.link = LINK_UP;
    next_s.traffic = PORT_BUSY;
    next_s.ua = UA_PRESENT;
    for (int i = 0; i < 16; i++) begin
      next_s.in_led[i] = DIGITAL_INPUT[i];
    end
    // Ready light, errors first
    if (SWITCH_INVALID) begin
      next_s.rdy = SLM_RED;
    end else if (!DEV_OPERATIONAL) begin
      next_s.rdy = SLM_OFF;
    end else if (US_UNDER || US_SURGE || OVERTEMP) begin
      next_s.rdy = s.blink ? SLM_YEL : SLM_GRN;
    end else if (FW_UPDATING) begin
      next_s.rdy = s.blink ? SLM_GRN : SLM_OFF;
    end else begin
      next_s.rdy = SLM_GRN;
    end
    // Network light
    if (!DEV_OPERATIONAL) begin
      next_s.net = SLM_OFF;
    end else if (NET_FAULT || WDOG_EXPIRED) begin
      next_s.net = SLM_RED;
    end else if (IP_CONFLICT) begin
      next_s.net = s.blink ? SLM_RED : SLM_OFF;
    end else if (IP_ZERO) begin
      next_s.net = SLM_YEL;
    end else if (ADDR_REQUESTING) begin
      next_s.net = s.blink ? SLM_YEL : SLM_OFF;
    end else if (|s.conn_open) begin
      next_s.net = SLM_GRN;
    end else begin
      next_s.net = s.blink ? SLM_GRN : SLM_OFF;
    end
    // Sensor supply light
    if (US_OVERLOAD) begin
      next_s.us = SLM_RED;
    end else if (US_PRESENT && !US_UNDER) begin
      next_s.us = SLM_GRN;
    end else begin
      next_s.us = SLM_OFF;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign RSP = s.rsp;
  assign CONN_OPEN = s.conn_open;
  assign CMD_ERR = s.cmd_err;
  assign PORT_LINK_LIGHT = s.link;
  assign PORT_TRAFFIC_LIGHT = s.traffic;
  assign RDY_LED = s.rdy;
  assign NET_LED = s.net;
  assign SENSOR_SUPPLY_LIGHT = s.us;
  assign ACTUATOR_SUPPLY_LIGHT = s.ua;
  assign IN_LED = s.in_led;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic rq_ok;
  assign rq_ok = REQ.valid && s.conn_open[REQ.conn];

  property p_link;
    ##1 PORT_LINK_LIGHT == $past(LINK_UP);
  endproperty
  a_link: assert property (p_link) else $error("link light wrong");
  property p_traffic;
    ##1 PORT_TRAFFIC_LIGHT == $past(PORT_BUSY);
  endproperty
  a_traffic: assert property (p_traffic) else $error("traffic light wrong");
  property p_in_led;
    ##1 IN_LED == $past(DIGITAL_INPUT);
  endproperty
  a_in_led: assert property (p_in_led) else $error("input light wrong");
  property p_ro_exc;
    rq_ok && is_wr && (REQ.addr == `SLM_ADDR_SUM) |=> RSP.valid && RSP.exc == `SLM_EXC_ADDR;
  endproperty
  a_ro_exc: assert property (p_ro_exc) else $error("read-only write not refused");
  property p_sum;
    rq_ok && is_rd && (REQ.addr == `SLM_ADDR_SUM) |=> RSP.data[0] == (|$past(s.fault));
  endproperty
  a_sum: assert property (p_sum) else $error("summary bit wrong");
  property p_in_word;
    rq_ok && is_rd && (REQ.addr == `SLM_ADDR_IN) |=> RSP.data == $past(in_word) && RSP.exc == 0;
  endproperty
  a_in_word: assert property (p_in_word) else $error("input word wrong");
  property p_rdy_red;
    SWITCH_INVALID |=> RDY_LED == SLM_RED;
  endproperty
  a_rdy_red: assert property (p_rdy_red) else $error("ready not red");
  property p_net_off;
    !DEV_OPERATIONAL |=> NET_LED == SLM_OFF;
  endproperty
  a_net_off: assert property (p_net_off) else $error("net light not dark");
  property p_blink;
    $changed(s.blink) |-> $past(s.cnt) == 24'(BLINK_HALF - 1);
  endproperty
  a_blink: assert property (p_blink) else $error("blink period wrong");
  property p_multi_cmd;
    rq_ok && is_wr && (REQ.addr == `SLM_ADDR_CMD) && !onehot |=>
      RSP.exc == `SLM_EXC_VALUE && CMD_ERR;
  endproperty
  a_multi_cmd: assert property (p_multi_cmd) else $error("bad command accepted");
  property p_reopen;
    CONN.open |=> CONN_OPEN[$past(CONN.id)];
  endproperty
  a_reopen: assert property (p_reopen) else $error("reopen refused");
  property p_rdy_fw;
    DEV_OPERATIONAL && FW_UPDATING && !SWITCH_INVALID && !US_UNDER && !US_SURGE && !OVERTEMP
      |=> RDY_LED == ($past(s.blink) ? SLM_GRN : SLM_OFF);
  endproperty
  a_rdy_fw: assert property (p_rdy_fw) else $error("ready flash wrong");
  property p_rdy_alt;
    DEV_OPERATIONAL && !SWITCH_INVALID && (US_UNDER || US_SURGE || OVERTEMP) |=>
      RDY_LED == ($past(s.blink) ? SLM_YEL : SLM_GRN);
  endproperty
  a_rdy_alt: assert property (p_rdy_alt) else $error("ready alternation wrong");
  property p_net_red;
    DEV_OPERATIONAL && (NET_FAULT || WDOG_EXPIRED) |=> NET_LED == SLM_RED;
  endproperty
  a_net_red: assert property (p_net_red) else $error("net light not red");
  property p_net_zero;
    DEV_OPERATIONAL && !NET_FAULT && !WDOG_EXPIRED && !IP_CONFLICT && IP_ZERO |=>
      NET_LED == SLM_YEL;
  endproperty
  a_net_zero: assert property (p_net_zero) else $error("net light not yellow");
  property p_net_dup;
    DEV_OPERATIONAL && !NET_FAULT && !WDOG_EXPIRED && IP_CONFLICT |=>
      NET_LED == ($past(s.blink) ? SLM_RED : SLM_OFF);
  endproperty
  a_net_dup: assert property (p_net_dup) else $error("net red flash wrong");
  property p_net_conn;
    DEV_OPERATIONAL && !NET_FAULT && !WDOG_EXPIRED && !IP_CONFLICT && !IP_ZERO &&
      !ADDR_REQUESTING && (|CONN_OPEN) |=> NET_LED == SLM_GRN;
  endproperty
  a_net_conn: assert property (p_net_conn) else $error("net light not green");
  property p_us_red;
    US_OVERLOAD |=> SENSOR_SUPPLY_LIGHT == SLM_RED;
  endproperty
  a_us_red: assert property (p_us_red) else $error("supply light not red");
  property p_ua;
    ##1 ACTUATOR_SUPPLY_LIGHT == $past(UA_PRESENT);
  endproperty
  a_ua: assert property (p_ua) else $error("actuator light wrong");
  property p_close;
    CONN.close && !CONN.open |=> !CONN_OPEN[$past(CONN.id)];
  endproperty
  a_close: assert property (p_close) else $error("slot not closed");
  c_read_in: cover property (rq_ok && is_rd && (REQ.addr == `SLM_ADDR_IN));
  c_clear: cover property (clr ##1 s.fault == 16'h0000);
  c_alt: cover property (RDY_LED == SLM_GRN ##1 RDY_LED == SLM_YEL);
  c_reopen: cover property (CONN.open && s.conn_open[CONN.id]);
endmodule : slm_top

// ### verification/slm_client.sv
// Remote register client model: opens slots and issues one-word requests
`timescale 1ns/10ps
module slm_client import slm_pkg::*; (
  input wire logic clk, // System clock
  output slm_conn_s conn, // Slot event
  output slm_req_s req // Register request
);
  initial begin
    conn = '0;
    req = '0;
  end
  task automatic slot(input logic op, input logic [2:0] id);
    @(posedge clk);
    conn <= '{open: op, close: !op, id: id};
    @(posedge clk);
    conn <= '0;
  endtask : slot
  task automatic send(input logic [7:0] fc, input logic wr, input logic [2:0] c,
                      input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{valid: 1'b1, fc: fc, wr: wr, conn: c, addr: a, wdata: d};
  endtask : send
  // Released fields never keep the last request
  task automatic idle();
    @(posedge clk);
    req <= {1'b0, ~req[43:0]};
  endtask : idle
endmodule : slm_client

// ### verification/status_leds_and_modbus_regs_tb_top.sv
// Self-checking bench of the indicator and register block
`timescale 1ns/10ps
`include "slm_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp=%h got=%h", nm, e, g); end end
module status_leds_and_modbus_regs_tb_top;
  import slm_pkg::*;
  typedef struct packed {
    logic op, fw, un, su, ov, ot, sw, rq, z, cf, nf, wd, pr;
  } slm_cond_s;
  typedef struct packed {logic [7:0] exc; logic [15:0] data; logic [15:0] m;} slm_exp_s;
  logic clk, rst, ua, cmd_err, ua_l;
  slm_cond_s cd;
  logic [1:0] link_up, busy, port_link_light, act;
  logic [15:0] di, w, in_led;
  logic [7:0] conn_open;
  slm_conn_s conn;
  slm_req_s req;
  slm_rsp_s rsp;
  slm_led_e rdy, net, us;
  int err_count, n_checks;
  slm_exp_s exp_q[$];
  slm_exp_s ex;
  logic [12:0] fcond [4] = '{13'h1400, 13'h1200, 13'h1100, 13'h1080};
  int fbit [4] = '{2, 3, 4, 10};
  slm_client cl (.clk(clk), .conn(conn), .req(req));
  slm_top #(.BLINK_HALF(4)) dut (.CLK(clk), .RST(rst), .LINK_UP(link_up), .PORT_BUSY(busy),
    .DEV_OPERATIONAL(cd.op), .FW_UPDATING(cd.fw), .US_UNDER(cd.un), .US_SURGE(cd.su),
    .US_OVERLOAD(cd.ov), .OVERTEMP(cd.ot), .SWITCH_INVALID(cd.sw), .ADDR_REQUESTING(cd.rq),
    .IP_ZERO(cd.z), .IP_CONFLICT(cd.cf), .NET_FAULT(cd.nf), .WDOG_EXPIRED(cd.wd),
    .US_PRESENT(cd.pr), .UA_PRESENT(ua), .DIGITAL_INPUT(di), .CONN(conn), .REQ(req),
    .RSP(rsp), .CONN_OPEN(conn_open), .CMD_ERR(cmd_err), .PORT_LINK_LIGHT(port_link_light),
    .PORT_TRAFFIC_LIGHT(act), .RDY_LED(rdy), .NET_LED(net), .SENSOR_SUPPLY_LIGHT(us),
    .ACTUATOR_SUPPLY_LIGHT(ua_l), .IN_LED(in_led));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic setc(input logic [12:0] c);
    @(posedge clk);
    cd <= c;
    repeat (2) @(negedge clk);
  endtask : setc
  // Watch a light over several blink periods; only colours a and b may show
  task automatic look(input logic [12:0] c, input logic n, input slm_led_e a,
                      input slm_led_e b);
    int ka = 0;
    int kb = 0;
    int ko = 0;
    setc(c);
    repeat (20) begin
      @(negedge clk);
      if ((n ? net : rdy) === a) ka++;
      else if ((n ? net : rdy) === b) kb++;
      else ko++;
    end
    `CHK("led", 1'b1, ko == 0 && ka > 0 && (kb > 0 || a == b))
  endtask : look
  task automatic rq(input logic [7:0] fc, input logic wr, input logic [2:0] c,
    input logic [15:0] a, input logic [15:0] d, input logic [7:0] e, input logic [15:0] x,
    input logic [15:0] m);
    exp_q.push_back('{e, x, m});
    cl.send(fc, wr, c, a, d);
  endtask : rq
  always @(negedge clk) begin
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK("rsp", 1'b0, 1'b1)
      else begin
        ex = exp_q.pop_front();
        `CHK("exc", ex.exc, rsp.exc)
        `CHK("data", ex.data & ex.m, rsp.data & ex.m)
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    `CHK("timeout", 1'b0, 1'b1)
    test_done();
  end
  initial begin
    rst = 1'b1;
    cd = '0;
    link_up = '0;
    busy = '0;
    ua = 1'b0;
    di = '0;
    void'($urandom(70));
    repeat (20) @(posedge clk);
    `CHK("rdy_rst", SLM_OFF, rdy)
    rst <= 1'b0;
    // ---------------------------------------------------------------
    // Plain lights
    // ---------------------------------------------------------------
    repeat (6) begin
      @(posedge clk);
      link_up <= 2'($urandom);
      busy <= 2'($urandom);
      ua <= 1'($urandom);
      di <= 16'($urandom);
      repeat (2) @(negedge clk);
      `CHK("link", link_up, port_link_light)
      `CHK("act", busy, act)
      `CHK("ua", ua, ua_l)
      `CHK("in", di, in_led)
    end
    w = {di[7:0], di[15:8]};
    // ---------------------------------------------------------------
    // Ready, network and sensor supply lights
    // ---------------------------------------------------------------
    look(13'h0000, 1'b0, SLM_OFF, SLM_OFF);
    look(13'h0000, 1'b1, SLM_OFF, SLM_OFF);
    look(13'h1000, 1'b0, SLM_GRN, SLM_GRN);
    look(13'h1000, 1'b1, SLM_GRN, SLM_OFF);
    look(13'h1800, 1'b0, SLM_GRN, SLM_OFF);
    look(13'h1400, 1'b0, SLM_YEL, SLM_GRN);
    look(13'h1200, 1'b0, SLM_YEL, SLM_GRN);
    look(13'h1080, 1'b0, SLM_YEL, SLM_GRN);
    look(13'h0040, 1'b0, SLM_RED, SLM_RED);
    look(13'h1440, 1'b0, SLM_RED, SLM_RED);
    look(13'h1020, 1'b1, SLM_YEL, SLM_OFF);
    look(13'h1030, 1'b1, SLM_YEL, SLM_YEL);
    look(13'h1008, 1'b1, SLM_RED, SLM_OFF);
    look(13'h1014, 1'b1, SLM_RED, SLM_RED);
    look(13'h1002, 1'b1, SLM_RED, SLM_RED);
    setc(13'h1101);
    `CHK("us", SLM_RED, us)
    setc(13'h1001);
    `CHK("us", SLM_GRN, us)
    setc(13'h1401);
    `CHK("us", SLM_OFF, us)
    setc(13'h1000);
    `CHK("us", SLM_OFF, us)
    // ---------------------------------------------------------------
    // Connections and register access
    // ---------------------------------------------------------------
    for (int i = 0; i < 8; i++) cl.slot(1'b1, i[2:0]);
    @(negedge clk);
    `CHK("slots", 8'hFF, conn_open)
    look(13'h1000, 1'b1, SLM_GRN, SLM_GRN);
    cl.slot(1'b0, 3'd5);
    @(negedge clk);
    `CHK("slots", 8'hDF, conn_open)
    `CHK("cmd_err", 1'b0, cmd_err)
    rq(`SLM_FC_RD_HOLD, 1'b0, 3'd0, `SLM_ADDR_IN, '0, `SLM_EXC_NONE, w, 16'hFFFF);
    rq(`SLM_FC_RD_INREG, 1'b0, 3'd1, `SLM_ADDR_IN, '0, `SLM_EXC_NONE, w, 16'hFFFF);
    rq(`SLM_FC_RW_REGS, 1'b0, 3'd2, `SLM_ADDR_IN, '0, `SLM_EXC_NONE, w, 16'hFFFF);
    for (int b = 0; b < 16; b++) begin
      rq(b[0] ? `SLM_FC_RD_DISC : `SLM_FC_RD_COILS, 1'b0, 3'd3, 16'(b), '0, `SLM_EXC_NONE,
         {15'h0000, w[b]}, 16'h0001);
    end
    rq(`SLM_FC_RD_COILS, 1'b0, 3'd4, 16'h0010, '0, `SLM_EXC_ADDR, '0, '0);
    rq(`SLM_FC_WR_COIL, 1'b1, 3'd0, 16'h0000, 16'h0001, `SLM_EXC_ADDR, '0, '0);
    rq(`SLM_FC_WR_COILS, 1'b1, 3'd0, 16'h0001, 16'h0001, `SLM_EXC_ADDR, '0, '0);
    rq(8'h07, 1'b0, 3'd0, `SLM_ADDR_IN, '0, `SLM_EXC_FUNC, '0, '0);
    rq(`SLM_FC_RD_HOLD, 1'b0, 3'd5, `SLM_ADDR_IN, '0, `SLM_EXC_FAIL, '0, '0);
    rq(`SLM_FC_WR_REG, 1'b1, 3'd0, `SLM_ADDR_IN, 16'h1234, `SLM_EXC_ADDR, '0, '0);
    rq(`SLM_FC_WR_REGS, 1'b1, 3'd6, `SLM_ADDR_SUM, 16'h0001, `SLM_EXC_ADDR, '0, '0);
    rq(`SLM_FC_RW_REGS, 1'b1, 3'd7, `SLM_ADDR_DET, 16'h0004, `SLM_EXC_ADDR, '0, '0);
    rq(`SLM_FC_RD_HOLD, 1'b0, 3'd0, `SLM_ADDR_CMD, '0, `SLM_EXC_ADDR, '0, '0);
    rq(`SLM_FC_WR_REG, 1'b1, 3'd0, `SLM_ADDR_CMD, 16'h0003, `SLM_EXC_VALUE, '0, '0);
    cl.idle();
    repeat (2) @(negedge clk);
    `CHK("cmd_err", 1'b1, cmd_err)
    cl.slot(1'b1, 3'd5);
    rq(`SLM_FC_RD_INREG, 1'b0, 3'd5, `SLM_ADDR_IN, '0, `SLM_EXC_NONE, w, 16'hFFFF);
    cl.idle();
    cl.slot(1'b1, 3'd3);
    @(negedge clk);
    `CHK("slots", 8'hFF, conn_open)
    // ---------------------------------------------------------------
    // Fault latch, summary bit and clear command
    // ---------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      rq(`SLM_FC_WR_REG, 1'b1, 3'd0, `SLM_ADDR_CMD, 16'h0080, `SLM_EXC_NONE, '0, '0);
      cl.idle();
      rq(`SLM_FC_RD_HOLD, 1'b0, 3'd1, `SLM_ADDR_SUM, '0, `SLM_EXC_NONE, '0, 16'hFFFF);
      cl.idle();
      setc(fcond[i]);
      setc(13'h1000);
      rq(`SLM_FC_RD_INREG, 1'b0, 3'd2, `SLM_ADDR_DET, '0, `SLM_EXC_NONE,
         16'h0001 << fbit[i], 16'hFFFF);
      rq(`SLM_FC_RW_REGS, 1'b0, 3'd3, `SLM_ADDR_SUM, '0, `SLM_EXC_NONE, 16'h0001,
         16'hFFFF);
      cl.idle();
    end
    repeat (4) @(negedge clk);
    `CHK("pending", 0, exp_q.size())
    test_done();
  end
endmodule : status_leds_and_modbus_regs_tb_top
